// ---- gpb_port_bank.sv ----
// Function
// - direction bit one makes the pin a general output
// - data writes go to latch; output pins drive latch directly
// - reading an output pin returns the latch
// - direction bit zero makes the pin a general input
// - writes to input pins only update the latch
// - input pins read the pin level; rmw reads return latch
// - peripheral output enable routes peripheral output onto pin
// - peripheral-driven pin reads pin level; rmw read returns latch
// - direction zero reads pin level even when peripheral uses input
// - reset clears all direction bits to inputs
// - isolate bit in stop/watch floats pins and forces input low, except pins kept open for port 0, serial or EC irqs
// - port 0 pins with external irq enabled keep input open
// - isolate bit zero in standby keeps pin state and level
// - port 0 pin levels feed the external interrupt circuit, gated low in isolation unless the pin's irq is enabled
// - pull-up enable bit one connects the pull-up
// - pull-up disconnected while the pin drives low
// - open-drain pins float when driven high
// - port 1 bit 2 pull-up is storage only, no effect
// - port 1 implements only bits 0 to 4
// - serial rx and clock pins stay open when irq routing enabled
`include "gpb_defs.svh"
`default_nettype none
module gpb_port_bank #(
    parameter logic [2:0][7:0] OPEN_DRAIN = '0
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire gpb_pkg::gpb_bank_t   padIn,
    output gpb_pkg::gpb_bank_t        padOut,
    output gpb_pkg::gpb_bank_t        padOe,
    output gpb_pkg::gpb_bank_t        padPullup,
    input  wire gpb_pkg::gpb_bank_t   periphOe,
    input  wire gpb_pkg::gpb_bank_t   periphOut,
    input  wire logic                 standbyEnter,
    input  wire logic [7:0]           extIrqEnable,
    output gpb_pkg::gpb_bank_t        periphIn,
    output logic [7:0]                extIrqPin
);
    localparam logic [2:0][7:0] IMPL = {`GPB_P2_MASK, `GPB_P1_MASK, 8'hFF};

    // refused at elaboration: open drain on a pin that does not exist
    if ((OPEN_DRAIN & ~IMPL) != '0) begin : g_bad_open_drain
        $error("open drain set on unimplemented bit");
    end

    gpb_pkg::gpb_state_t s_q;
    gpb_pkg::gpb_state_t s_d;

    logic       wrGo;
    logic       rdGo;
    logic [1:0] wrPort;
    logic [1:0] rdPort;
    logic [7:0] rdByte;
    logic       rdHit;
    logic       isolate;
    gpb_pkg::gpb_bank_t keepOpen;
    gpb_pkg::gpb_bank_t drive;
    gpb_pkg::gpb_bank_t level;

    always_comb begin
        s_d = s_q;
        // pin inputs through three stages; change counts when 2 and 3 agree
        s_d.sync1 = padIn;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        for (int b = 0; b < 24; b++) begin
            if (s_q.sync2[b / 8][b % 8] == s_q.sync3[b / 8][b % 8]) begin
                s_d.pinLevel[b / 8][b % 8] = s_q.sync2[b / 8][b % 8];
            end
        end

        // isolation only in stop/watch with the isolate bit
        isolate = s_q.ctrl[`GPB_CTRL_ISOLATE] & standbyEnter;
        s_d.ctrl[`GPB_CTRL_STANDBY] = standbyEnter;
        keepOpen = '0;
        // irq-enabled port 0 inputs stay open
        keepOpen[0] = extIrqEnable;
        // serial rx and clock kept open by irq routing
        keepOpen[1][`GPB_P1_RX_BIT]  = s_q.ctrl[`GPB_CTRL_SERIRQ];
        keepOpen[1][`GPB_P1_SCK_BIT] = s_q.ctrl[`GPB_CTRL_SERIRQ];
        keepOpen[2][`GPB_P2_EC_BIT]  = s_q.ctrl[`GPB_CTRL_ECIRQ];

        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 8; i++) begin
                // peripheral output wins over the port latch
                drive[p][i] = periphOe[p][i] ? periphOut[p][i] : s_q.latch[p][i];
                // without isolation the pin keeps its state
                if (isolate || !IMPL[p][i]) begin
                    s_d.padOe[p][i] = 1'b0;
                end else begin
                    s_d.padOe[p][i] = (s_q.dir[p][i] | periphOe[p][i]) &
                                      ~(OPEN_DRAIN[p][i] & drive[p][i]);
                end
                // peripheral output or latch value to the pad, registered
                s_d.padOut[p][i] = drive[p][i];
                s_d.padPull[p][i] = s_q.pull[p][i] & IMPL[p][i] &
                                    ~(s_d.padOe[p][i] & ~drive[p][i]);
                s_d.inGate[p][i] = ~isolate | keepOpen[p][i];
                level[p][i] = s_q.pinLevel[p][i] & s_d.inGate[p][i];
            end
        end
        s_d.padPull[1][`GPB_P1_NOPULL_BIT] = 1'b0;
        // port 0 levels to the irq circuit, gated like the inputs in isolation
        s_d.extIrqPin = s_q.pinLevel[0] & s_d.inGate[0];
        // registered so the peripheral side sees no gate glitches
        s_d.periphIn = s_d.pinLevel & s_d.inGate;

        // write channel: address and data in either order
        s_d.bus.awReady = 1'b0;
        s_d.bus.wReady  = 1'b0;
        s_d.bus.arReady = 1'b0;
        if (s_axi_awvalid && s_q.bus.awReady) begin
            s_d.bus.awHeld = 1'b1;
            s_d.bus.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.bus.wReady) begin
            s_d.bus.wHeld = 1'b1;
            s_d.bus.wData = s_axi_wdata;
            s_d.bus.wStrb = s_axi_wstrb;
        end
        if (!s_d.bus.awHeld && !s_q.bus.bValid && !s_q.bus.awReady) s_d.bus.awReady = s_axi_awvalid;
        if (!s_d.bus.wHeld && !s_q.bus.bValid && !s_q.bus.wReady) s_d.bus.wReady = s_axi_wvalid;
        wrGo = s_q.bus.awHeld & s_q.bus.wHeld & ~s_q.bus.bValid;
        wrPort = 2'(s_q.bus.awAddr / 12);
        if (wrGo) begin
            s_d.bus.awHeld = 1'b0;
            s_d.bus.wHeld  = 1'b0;
            s_d.bus.bValid = 1'b1;
            s_d.bus.bResp  = `GPB_RESP_OKAY;
            // byte lane 0 only, effective next edge
            if (s_q.bus.wStrb[0]) begin
                unique case (s_q.bus.awAddr)
                    // writes always land in the latch
                    `GPB_ADDR_P0_LATCH, `GPB_ADDR_P1_LATCH, `GPB_ADDR_P2_LATCH:
                        s_d.latch[wrPort] = s_q.bus.wData[7:0] & IMPL[wrPort];
                    `GPB_ADDR_P0_DIR, `GPB_ADDR_P1_DIR, `GPB_ADDR_P2_DIR:
                        s_d.dir[wrPort] = s_q.bus.wData[7:0] & IMPL[wrPort];
                    `GPB_ADDR_P0_PULLUP, `GPB_ADDR_P1_PULLUP, `GPB_ADDR_P2_PULLUP:
                        s_d.pull[wrPort] = s_q.bus.wData[7:0] & IMPL[wrPort];
                    `GPB_ADDR_CTRL: begin
                        s_d.ctrl[`GPB_CTRL_ISOLATE] = s_q.bus.wData[`GPB_CTRL_ISOLATE];
                        s_d.ctrl[`GPB_CTRL_SERIRQ]  = s_q.bus.wData[`GPB_CTRL_SERIRQ];
                        s_d.ctrl[`GPB_CTRL_ECIRQ]   = s_q.bus.wData[`GPB_CTRL_ECIRQ];
                    end
                    `GPB_ADDR_RMW_LATCH0, `GPB_ADDR_RMW_LATCH1, `GPB_ADDR_RMW_LATCH2: ;
                    default: s_d.bus.bResp = `GPB_RESP_SLVERR;
                endcase
            end
        end
        if (s_q.bus.bValid && s_axi_bready) s_d.bus.bValid = 1'b0;

        // read channel
        rdGo = s_axi_arvalid & s_q.bus.arReady;
        if (!s_q.bus.rValid && !s_q.bus.arReady) s_d.bus.arReady = s_axi_arvalid;
        rdPort = 2'(s_axi_araddr / 12);
        rdHit  = 1'b1;
        rdByte = `GPB_RESET_BYTE;
        unique case (s_axi_araddr)
            // output reads latch, others the pin
            `GPB_ADDR_P0_LATCH, `GPB_ADDR_P1_LATCH, `GPB_ADDR_P2_LATCH:
                rdByte = ((s_q.dir[rdPort] & ~periphOe[rdPort] & s_q.latch[rdPort]) |
                          (~(s_q.dir[rdPort] & ~periphOe[rdPort]) & level[rdPort])) & IMPL[rdPort];
            `GPB_ADDR_P0_DIR, `GPB_ADDR_P1_DIR, `GPB_ADDR_P2_DIR:
                rdByte = s_q.dir[rdPort];
            `GPB_ADDR_P0_PULLUP, `GPB_ADDR_P1_PULLUP, `GPB_ADDR_P2_PULLUP:
                rdByte = s_q.pull[rdPort];
            `GPB_ADDR_CTRL:
                rdByte = {4'h0, s_q.ctrl};
            `GPB_ADDR_RMW_LATCH0: rdByte = s_q.latch[0];
            `GPB_ADDR_RMW_LATCH1: rdByte = s_q.latch[1];
            `GPB_ADDR_RMW_LATCH2: rdByte = s_q.latch[2];
            default: rdHit = 1'b0;
        endcase
        if (rdGo) begin
            s_d.bus.rValid = 1'b1;
            s_d.bus.rData  = {24'h00_0000, rdByte};
            s_d.bus.rResp  = rdHit ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
        end else if (s_q.bus.rValid && s_axi_rready) begin
            s_d.bus.rValid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.bus.awReady;
    assign s_axi_wready  = s_q.bus.wReady;
    assign s_axi_bvalid  = s_q.bus.bValid;
    assign s_axi_bresp   = s_q.bus.bResp;
    assign s_axi_arready = s_q.bus.arReady;
    assign s_axi_rvalid  = s_q.bus.rValid;
    assign s_axi_rdata   = s_q.bus.rData;
    assign s_axi_rresp   = s_q.bus.rResp;
    assign padOut        = s_q.padOut;
    assign padOe         = s_q.padOe;
    assign padPullup     = s_q.padPull;
    assign periphIn      = s_q.periphIn;
    assign extIrqPin     = s_q.extIrqPin;

    chk_reset_inputs: assert property (@(posedge clk) $rose(resetn) |-> s_q.dir == '0)
        else $error("direction not cleared by reset");
    chk_isolate_float: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.ctrl[`GPB_CTRL_ISOLATE] && standbyEnter) |=> padOe == '0)
        else $error("pin driven during isolation");
    chk_output_drive: assert property (@(posedge clk) disable iff (!resetn)
        (!standbyEnter && s_q.dir[0][0] && !periphOe[0][0] && !OPEN_DRAIN[0][0])
        |=> padOe[0][0] && padOut[0][0] == $past(s_q.latch[0][0]))
        else $error("output pin not driving latch");
    chk_input_float: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.dir[2][1] == 1'b0 && !periphOe[2][1]) |=> !padOe[2][1])
        else $error("input pin driven");
    chk_pull_low: assert property (@(posedge clk) disable iff (!resetn)
        (padOe[0][3] && !padOut[0][3]) |-> !padPullup[0][3])
        else $error("pull-up on low driven pin");
    chk_debug_nopull: assert property (@(posedge clk) disable iff (!resetn)
        !padPullup[1][`GPB_P1_NOPULL_BIT])
        else $error("pull-up on debug pin");
    chk_p1_upper: assert property (@(posedge clk) disable iff (!resetn)
        s_q.dir[1][7:5] == 3'b000 && s_q.latch[1][7:5] == 3'b000)
        else $error("port 1 upper bits set");
    // write lands one edge after both halves are held
    chk_write_next: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.bus.awHeld && s_q.bus.wHeld && !s_q.bus.bValid && s_q.bus.wStrb[0]
         && s_q.bus.awAddr == `GPB_ADDR_P0_DIR) |=> s_q.dir[0] == $past(s_q.bus.wData[7:0]))
        else $error("direction write not applied");
    // irq enabled port 0 input open in isolation
    chk_irq_open: assert property (@(posedge clk) disable iff (!resetn)
        extIrqEnable[0] |=> s_q.inGate[0][0])
        else $error("irq input gated");
    chk_periph_route: assert property (@(posedge clk) disable iff (!resetn)
        (!standbyEnter && periphOe[2][0] && !OPEN_DRAIN[2][0])
        |=> padOe[2][0] && padOut[2][0] == $past(periphOut[2][0]))
        else $error("peripheral output not on pin");
    chk_pull_connect: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.pull[0][5] && !s_q.dir[0][5] && !periphOe[0][5]) |=> padPullup[0][5])
        else $error("pull-up not connected");
    // port 0 levels reach the irq circuit
    chk_irq_feed: assert property (@(posedge clk) disable iff (!resetn)
        !isolate |=> extIrqPin == $past(s_q.pinLevel[0]))
        else $error("pin level missing at irq circuit");
endmodule
`default_nettype wire

// ---- gpb_defs.svh ----
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH
// register byte addresses
`define GPB_ADDR_P0_LATCH   8'h00
`define GPB_ADDR_P0_DIR     8'h04
`define GPB_ADDR_P0_PULLUP  8'h08
`define GPB_ADDR_P1_LATCH   8'h0C
`define GPB_ADDR_P1_DIR     8'h10
`define GPB_ADDR_P1_PULLUP  8'h14
`define GPB_ADDR_P2_LATCH   8'h18
`define GPB_ADDR_P2_DIR     8'h1C
`define GPB_ADDR_P2_PULLUP  8'h20
`define GPB_ADDR_CTRL       8'h24
`define GPB_ADDR_RMW_LATCH0 8'h28
`define GPB_ADDR_RMW_LATCH1 8'h2C
`define GPB_ADDR_RMW_LATCH2 8'h30
`define GPB_ADDR_BITS       8
// field positions and masks
`define GPB_P1_MASK         8'h1F
`define GPB_P2_MASK         8'h1F
`define GPB_P1_NOPULL_BIT   2
`define GPB_CTRL_ISOLATE    0
`define GPB_CTRL_STANDBY    1
`define GPB_CTRL_SERIRQ     2
`define GPB_CTRL_ECIRQ      3
`define GPB_P1_RX_BIT       0
`define GPB_P1_SCK_BIT      3
`define GPB_P2_EC_BIT       4
`define GPB_RESET_BYTE      8'h00
`define GPB_RESP_OKAY       2'b00
`define GPB_RESP_SLVERR     2'b10
`endif

// ---- gpb_pkg.sv ----
`default_nettype none
package gpb_pkg;
    typedef logic [2:0][7:0] gpb_bank_t;
    typedef struct packed {
        logic        bValid;
        logic        arReady;
        logic        awReady;
        logic        wReady;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [1:0]  bResp;
        logic        awHeld;
        logic        wHeld;
        logic [7:0]  awAddr;
        logic [31:0] wData;
        logic [3:0]  wStrb;
    } gpb_bus_t;
    typedef struct packed {
        gpb_bank_t  latch;
        gpb_bank_t  dir;
        gpb_bank_t  pull;
        logic [3:0] ctrl;
        gpb_bank_t  sync1;
        gpb_bank_t  sync2;
        gpb_bank_t  sync3;
        gpb_bank_t  pinLevel;
        gpb_bank_t  padOut;
        gpb_bank_t  padOe;
        gpb_bank_t  padPull;
        gpb_bank_t  inGate;
        logic [7:0] extIrqPin;
        gpb_bank_t  periphIn;
        gpb_bus_t   bus;
    } gpb_state_t;
endpackage
`default_nettype wire

// ---- gpb_pin_model.sv ----
`default_nettype none
module gpb_pin_model (
    input  wire logic               clk,
    input  wire gpb_pkg::gpb_bank_t padOut,
    input  wire gpb_pkg::gpb_bank_t padOe,
    input  wire gpb_pkg::gpb_bank_t padPullup,
    input  wire gpb_pkg::gpb_bank_t extDrv,
    input  wire gpb_pkg::gpb_bank_t extVal,
    output gpb_pkg::gpb_bank_t      padIn
);
    timeunit 1ns;
    timeprecision 1ns;
    gpb_pkg::gpb_bank_t floatQ = '0;
    // undriven lines wander so a stale value never reads as a match
    always @(posedge clk) floatQ <= ~floatQ;
    // device drive wins, then outside drive, then pull-up or float
    assign padIn = (padOe & padOut) | (~padOe & extDrv & extVal) | (~padOe & ~extDrv & (padPullup | floatQ));
endmodule
`default_nettype wire

// ---- gpb_port_bank_bench.sv ----
`include "gpb_defs.svh"
`default_nettype none
module gpb_port_bank_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk = 0, resetn = 0;
    logic [7:0]         s_axi_awaddr = '0, s_axi_araddr = '0, extIrqEnable = '0, rdD;
    logic [31:0]        s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]         s_axi_wstrb = 4'h1;
    logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic               s_axi_rready = 0, standbyEnter = 0, s_axi_awready, s_axi_wready;
    logic               s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]         s_axi_bresp, s_axi_rresp, rdR, wrR;
    gpb_pkg::gpb_bank_t padIn, padOut, padOe, padPullup, periphIn;
    gpb_pkg::gpb_bank_t periphOe = '0, periphOut = '0, extDrv = '0, extVal = '0;
    logic [7:0]         extIrqPin;
    int                 nMismatch = 0, numChecks = 0;
    gpb_port_bank #(.OPEN_DRAIN(24'h00_0200)) gpb_port_bank_inst (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .padPullup(padPullup), .periphOe(periphOe), .periphOut(periphOut),
        .standbyEnter(standbyEnter), .extIrqEnable(extIrqEnable), .periphIn(periphIn), .extIrqPin(extIrqPin));
    gpb_pin_model gpb_pin_model_inst (.clk(clk), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
        .extDrv(extDrv), .extVal(extVal), .padIn(padIn));
    initial forever #50 clk = ~clk;
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        numChecks++;
        if (g !== e) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // readies are registered, so the value at the falling edge is the one the next rising edge takes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bit aDone, wDone;
        int n;
        aDone = 0;
        wDone = 0;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(aDone && wDone) && n < 50) begin
            @(negedge clk);
            n++;
            if (s_axi_awready) aDone = 1;
            if (s_axi_wready) wDone = 1;
            @(posedge clk);
            if (aDone) s_axi_awvalid <= 0;
            if (wDone) s_axi_wvalid <= 0;
        end
        do begin
            @(negedge clk);
            n++;
        end while (!s_axi_bvalid && n < 100);
        wrR = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 0;
        if (n >= 100) nMismatch++;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(negedge clk);
            n++;
        end while (!s_axi_arready && n < 50);
        @(posedge clk);
        s_axi_arvalid <= 0;
        do begin
            @(negedge clk);
            n++;
        end while (!s_axi_rvalid && n < 100);
        rdD = s_axi_rdata[7:0];
        rdR = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 0;
        if (n >= 100) nMismatch++;
    endtask
    task automatic tReset();
        for (int p = 0; p < 3; p++) chk("padOe", 8'h00, padOe[p]);
        rd(`GPB_ADDR_P1_DIR);
        chk("dir1", 8'h00, rdD);
    endtask
    task automatic tOutput();
        wr(`GPB_ADDR_P0_DIR, 8'hFF);
        wr(`GPB_ADDR_P0_LATCH, 8'hA5);
        step(2);
        chk("padOe0", 8'hFF, padOe[0]);
        chk("padOut0", 8'hA5, padOut[0]);
        wr(`GPB_ADDR_P1_DIR, 8'hFF);
        rd(`GPB_ADDR_P1_DIR);
        chk("dir1", 8'h1F, rdD);
        wr(`GPB_ADDR_P1_LATCH, 8'h02);
        step(2);
        chk("padOe1", 8'h1D, padOe[1]);
        rd(`GPB_ADDR_P1_LATCH);
        chk("latch1", 8'h02, rdD);
    endtask
    task automatic tInput();
        wr(`GPB_ADDR_P0_DIR, 8'h00);
        extDrv[0] <= 8'hFF;
        extVal[0] <= 8'h3C;
        wr(`GPB_ADDR_P0_LATCH, 8'hC3);
        step(6);
        chk("padOe0", 8'h00, padOe[0]);
        chk("extIrqPin", 8'h3C, extIrqPin);
        rd(`GPB_ADDR_P0_LATCH);
        chk("pin0", 8'h3C, rdD);
        rd(`GPB_ADDR_RMW_LATCH0);
        chk("rmw0", 8'hC3, rdD);
        extDrv[0] <= 8'h00;
    endtask
    task automatic tPeriph();
        extDrv[2] <= 8'h1E;
        wr(`GPB_ADDR_P2_DIR, 8'h01);
        wr(`GPB_ADDR_P2_LATCH, 8'h00);
        periphOe[2] <= 8'h01;
        periphOut[2] <= 8'h01;
        step(6);
        chk("padOut2", 8'h01, padOut[2] & 8'h01);
        rd(`GPB_ADDR_P2_LATCH);
        chk("pin2", 8'h01, rdD);
        rd(`GPB_ADDR_RMW_LATCH2);
        chk("rmw2", 8'h00, rdD);
        // peripheral output off before the pin serves as a port again
        periphOe[2] <= 8'h00;
    endtask
    task automatic tPull();
        wr(`GPB_ADDR_P0_PULLUP, 8'hFF);
        wr(`GPB_ADDR_P0_DIR, 8'hFF);
        wr(`GPB_ADDR_P0_LATCH, 8'h0F);
        wr(`GPB_ADDR_P1_PULLUP, 8'hFF);
        step(2);
        chk("pull0", 8'h0F, padPullup[0]);
        chk("pull1b2", 8'h00, padPullup[1] & 8'h04);
        rd(`GPB_ADDR_P1_PULLUP);
        chk("pullReg1", 8'h1F, rdD);
    endtask
    task automatic tStandby();
        wr(`GPB_ADDR_CTRL, 8'h01);
        extIrqEnable <= 8'h01;
        standbyEnter <= 1;
        extDrv[0] <= 8'hFF;
        extVal[0] <= 8'hFF;
        step(6);
        chk("isoOe0", 8'h00, padOe[0]);
        chk("isoIn0", 8'h01, periphIn[0]);
        wr(`GPB_ADDR_CTRL, 8'h05);
        step(6);
        chk("isoIn1", 8'h09, periphIn[1] & 8'h09);
        wr(`GPB_ADDR_CTRL, 8'h00);
        step(6);
        chk("holdOe0", 8'hFF, padOe[0]);
        standbyEnter <= 0;
        rd(8'h40);
        chk("resp", {6'h00, `GPB_RESP_SLVERR}, {6'h00, rdR});
        wr(8'h40, 8'h55);
        chk("bresp", {6'h00, `GPB_RESP_SLVERR}, {6'h00, wrR});
    endtask
    task automatic wrapUp();
        if (nMismatch == 0 && numChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        step(5);
        resetn <= 1;
        step(1);
        tReset();
        tOutput();
        tInput();
        tPeriph();
        tPull();
        tStandby();
        wrapUp();
    end
    initial begin
        #2_000_000;
        nMismatch++;
        wrapUp();
    end
endmodule
`default_nettype wire
